// [hdl/ics_channel_status.sv]
// One I2C channel: transaction result table, command bits and sequence control
`timescale 1ns/10ps
`default_nettype none

module ics_channel_status #(
   parameter int CHANNEL = 0,
   parameter int DEPTH   = ics_pkg::TABLE_DEPTH
) (
   // System
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Parallel host port pins
   input  wire logic       hostCsN,
   input  wire logic       hostRdN,
   input  wire logic       hostWrN,
   input  wire logic [7:0] hostAddr,
   input  wire logic [7:0] hostDataIn,
   output logic      [7:0] hostDataOut,
   output logic            hostDataOeN,
   // Serial bus pins, observed only
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   // Channel settings held outside this block
   input  wire logic [7:0] loopRepeatCount,
   input  wire logic [6:0] loadedCount,
   // Serial engine events
   input  wire logic       engXferBegin,
   input  wire logic       engXferEnd,
   input  wire logic       engSeqEnd,
   input  wire logic [5:0] engIndex,
   input  wire logic       engReadAddrNack,
   input  wire logic       engWriteAddrNack,
   input  wire logic       engWriteByteNack,
   // Serial engine requests
   output logic            seqStart,
   output logic            haltAfterByte,
   output logic            haltAfterSequence,
   // Condition and interrupt
   output logic            sdaFault,
   output logic            sclFault,
   output logic            intN
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks and addresses
   if (CHANNEL < 0 || CHANNEL > 2) begin : gBadChannel
      $error("CHANNEL must be 0, 1 or 2");
   end
   if (DEPTH < 1 || DEPTH > 64) begin : gBadDepth
      $error("DEPTH must be 1 to 64");
   end

   localparam logic [7:0] CMD_OFS = (CHANNEL == 0) ? ics_pkg::CMD_OFS_CH0 :
                                    (CHANNEL == 1) ? ics_pkg::CMD_OFS_CH1 : ics_pkg::CMD_OFS_CH2;
   localparam logic [7:0] RES_OFS = (CHANNEL == 0) ? ics_pkg::RESULT_OFS_A :
                                    (CHANNEL == 1) ? ics_pkg::RESULT_OFS_B : ics_pkg::RESULT_OFS_C;

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [DEPTH-1:0][ics_pkg::RESULT_WIDTH-1:0] status;
      ics_pkg::ics_chan_t                          state;
      logic                                        haltSeq;
      logic                                        beginReq;
      logic                                        haltByte;
      logic [4:0]                                  cmdLow;
      logic [7:0]                                  loops;
      logic                                        sdaFault;
      logic                                        sclFault;
      logic                                        prevRdN;
      logic                                        prevWrN;
      logic                                        prevScl;
      logic                                        prevSda;
      logic [7:0]                                  rdData;
      logic                                        seqStart;
   } ics_regs_t;

   ics_regs_t st;
   ics_regs_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   logic [20:0] syncBus;
   logic        csS;
   logic        rdS;
   logic        wrS;
   logic        sclS;
   logic        sdaS;
   logic [7:0]  addrS;
   logic [7:0]  dataS;

   ics_sync #(
      .WIDTH     (21),
      .RESET_VAL (21'h1FFFFF)
   ) uSync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .pinIn   ({hostCsN, hostRdN, hostWrN, sclIn, sdaIn, hostAddr, hostDataIn}),
      .syncOut (syncBus)
   );

   assign {csS, rdS, wrS, sclS, sdaS, addrS, dataS} = syncBus;

   ////////////////////////////////////////////////////////////////////////////
   // Decode and edge detection
   logic       rdEdge;
   logic       wrEdge;
   logic       cmdHit;
   logic       resHit;
   logic [5:0] rdIdx;
   logic       engIdxOk;
   logic       stopSeen;
   logic       busFree;
   logic [7:0] loopsInc;

   // Strobes act on their falling edge, address and data travel with them
   assign rdEdge   = st.prevRdN & ~rdS & ~csS;
   assign wrEdge   = st.prevWrN & ~wrS & ~csS;
   assign cmdHit   = (addrS == CMD_OFS);
   assign rdIdx    = addrS[5:0];
   assign resHit   = (addrS[7:6] == RES_OFS[7:6]) && (int'(rdIdx) < DEPTH);
   assign engIdxOk = int'(engIndex) < DEPTH;
   // STOP on the wire: SDA rises while SCL stays high
   assign stopSeen = st.prevScl & sclS & ~st.prevSda & sdaS;
   assign busFree  = sclS & sdaS;
   assign loopsInc = (st.loops == ics_pkg::LOOP_MAX) ? st.loops : 8'(st.loops + 8'h01);

   ////////////////////////////////////////////////////////////////////////////
   // Per-entry interrupt sources
   logic [DEPTH-1:0] alarm;

   for (genvar g = 0; g < DEPTH; g++) begin : gAlarm
      // Only the NACK bits raise a request; active and queued do not
      assign alarm[g] = |st.status[g][ics_pkg::RES_RA_NACK:ics_pkg::RES_DATA_NACK];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   logic doStart;
   logic doClear;

   always_comb begin
      next_st          = st;
      doStart          = 1'b0;
      doClear          = 1'b0;
      next_st.seqStart = 1'b0;
      next_st.prevRdN  = rdS;
      next_st.prevWrN  = wrS;
      next_st.prevScl  = sclS;
      next_st.prevSda  = sdaS;

      // Host write to the command register
      if (wrEdge && cmdHit) begin
         next_st.haltSeq  = dataS[ics_pkg::CMD_HALT_SEQ_BIT];
         next_st.haltByte = dataS[ics_pkg::CMD_HALT_BYTE_BIT];
         next_st.cmdLow   = dataS[4:0] & ics_pkg::CMD_LOW_MASK;
         if (!dataS[ics_pkg::CMD_BEGIN_BIT]) begin
            next_st.beginReq = 1'b0;
         end else if (!st.beginReq && st.state == ics_pkg::CH_IDLE) begin
            if (busFree) begin
               next_st.beginReq = 1'b1;
               next_st.state    = ics_pkg::CH_ACTIVE;
               next_st.loops    = 8'h00;
               next_st.sdaFault = 1'b0;
               next_st.sclFault = 1'b0;
               doStart          = 1'b1;
               doClear          = 1'b1;
            end else begin
               // Busy bus: report which line is held, no START
               next_st.sdaFault = ~sdaS;
               next_st.sclFault = ~sclS;
            end
         end
      end

      // Host read; a result byte is consumed by the read
      if (rdEdge) begin
         if (resHit) begin
            next_st.rdData         = {ics_pkg::RESULT_PAD, st.status[rdIdx]};
            next_st.status[rdIdx]  = ics_pkg::RESULT_RESET;
         end else if (cmdHit) begin
            next_st.rdData = {st.haltSeq, st.beginReq, st.haltByte, st.cmdLow};
         end else begin
            next_st.rdData = ics_pkg::READ_NONE;
         end
      end

      // End of one pass through the sequence
      if (engSeqEnd && st.state == ics_pkg::CH_ACTIVE) begin
         next_st.loops = loopsInc;
         if (st.haltSeq) begin
            // Engine sends STOP now; wait to see it on the wire
            next_st.beginReq = 1'b0;
            next_st.state    = ics_pkg::CH_STOPPING;
         end else if (loopRepeatCount == ics_pkg::LOOP_ONE ||
                      (loopRepeatCount > ics_pkg::LOOP_ONE && loopsInc >= loopRepeatCount)) begin
            next_st.beginReq = 1'b0;
            next_st.state    = ics_pkg::CH_IDLE;
         end else begin
            // Further loop; only a single-pass count would clear here
            doStart = 1'b1;
            doClear = (loopRepeatCount == ics_pkg::LOOP_ONE);
         end
      end

      // Mark the table at START: first active, the rest below loadedCount queued
      if (doStart) begin
         next_st.seqStart = 1'b1;
         for (int i = 0; i < DEPTH; i++) begin
            if (doClear) begin
               next_st.status[i] = ics_pkg::RESULT_RESET;
            end
            if (i == 0) begin
               next_st.status[i][ics_pkg::RES_ACTIVE:ics_pkg::RES_QUEUED] = ics_pkg::PHASE_ACTIVE;
            end else if (i < int'(loadedCount)) begin
               next_st.status[i][ics_pkg::RES_QUEUED] = 1'b1;
            end
         end
      end

      // Engine events come after the read so a same-cycle read clear loses to them
      if (engXferBegin && engIdxOk) begin
         next_st.status[engIndex][ics_pkg::RES_ACTIVE:ics_pkg::RES_QUEUED] = ics_pkg::PHASE_ACTIVE;
      end
      if (engXferEnd && engIdxOk) begin
         next_st.status[engIndex][ics_pkg::RES_ACTIVE:ics_pkg::RES_QUEUED] = ics_pkg::PHASE_NONE;
         next_st.status[engIndex][ics_pkg::RES_RA_NACK] = st.status[engIndex][ics_pkg::RES_RA_NACK] |
                                                          engReadAddrNack;
         next_st.status[engIndex][ics_pkg::RES_WA_NACK] = st.status[engIndex][ics_pkg::RES_WA_NACK] |
                                                          engWriteAddrNack;
         next_st.status[engIndex][ics_pkg::RES_DATA_NACK] = st.status[engIndex][ics_pkg::RES_DATA_NACK] |
                                                            engWriteByteNack;
      end

      // STOP on the wire ends both halt requests
      if (stopSeen) begin
         next_st.haltByte = 1'b0;
         next_st.haltSeq  = 1'b0;
         if (st.state == ics_pkg::CH_STOPPING ||
             (st.state == ics_pkg::CH_ACTIVE && st.haltByte)) begin
            next_st.state    = ics_pkg::CH_IDLE;
            next_st.beginReq = 1'b0;
            // Abandoned entries lose their queued and active marks, errors stay
            for (int i = 0; i < DEPTH; i++) begin
               next_st.status[i][ics_pkg::RES_ACTIVE:ics_pkg::RES_QUEUED] = ics_pkg::PHASE_NONE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st          <= '0;
         st.state    <= ics_pkg::CH_IDLE;
         st.prevRdN  <= 1'b1;
         st.prevWrN  <= 1'b1;
         st.prevScl  <= 1'b1;
         st.prevSda  <= 1'b1;
         st.rdData   <= ics_pkg::READ_NONE;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign hostDataOut       = st.rdData;
   // Drive the data pins only while the host is reading
   assign hostDataOeN       = ~(~csS & ~rdS);
   assign seqStart          = st.seqStart;
   assign haltAfterByte     = st.haltByte;
   assign haltAfterSequence = st.haltSeq;
   assign sdaFault          = st.sdaFault;
   assign sclFault          = st.sclFault;
   // Level, not pulse: stays low while any NACK byte is unread or a line fault is set
   assign intN              = ~(|alarm | st.sdaFault | st.sclFault);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   upper_bits_zero_a : assert property (@(posedge sys_clk) disable iff (reset)
      rdEdge && resHit |=> st.rdData[7:5] == 3'h0)
      else $error("result read shows upper bits set");

   int_on_nack_a : assert property (@(posedge sys_clk) disable iff (reset)
      engXferEnd && engIdxOk && (engReadAddrNack || engWriteAddrNack || engWriteByteNack)
      |=> !intN)
      else $error("NACK result did not pull interrupt low");

   read_clears_a : assert property (@(posedge sys_clk) disable iff (reset)
      rdEdge && resHit && !engXferBegin && !engXferEnd && !doStart
      |=> st.status[$past(rdIdx)] == ics_pkg::RESULT_RESET)
      else $error("result byte not cleared by read");

   read_nack_bit_a : assert property (@(posedge sys_clk) disable iff (reset)
      engXferEnd && engIdxOk && engReadAddrNack |=> st.status[$past(engIndex)][ics_pkg::RES_RA_NACK])
      else $error("read address NACK not recorded");

   write_nack_bit_a : assert property (@(posedge sys_clk) disable iff (reset)
      engXferEnd && engIdxOk && engWriteAddrNack |=> st.status[$past(engIndex)][ics_pkg::RES_WA_NACK])
      else $error("write address NACK not recorded");

   data_nack_bit_a : assert property (@(posedge sys_clk) disable iff (reset)
      engXferEnd && engIdxOk && engWriteByteNack |=> st.status[$past(engIndex)][ics_pkg::RES_DATA_NACK])
      else $error("write data NACK not recorded");

   idle_no_int_a : assert property (@(posedge sys_clk) disable iff (reset)
      (st.status == '0) && !st.sdaFault && !st.sclFault |-> intN)
      else $error("interrupt low with clear table");

   start_marks_a : assert property (@(posedge sys_clk) disable iff (reset)
      doStart && !engXferBegin && !engXferEnd && !stopSeen
      |=> seqStart && st.status[0][ics_pkg::RES_ACTIVE:ics_pkg::RES_QUEUED] == ics_pkg::PHASE_ACTIVE)
      else $error("START did not mark first entry active");

   stop_clears_a : assert property (@(posedge sys_clk) disable iff (reset)
      stopSeen |=> !haltAfterByte && !haltAfterSequence)
      else $error("STOP did not clear halt bits");

   busy_fault_a : assert property (@(posedge sys_clk) disable iff (reset)
      wrEdge && cmdHit && dataS[ics_pkg::CMD_BEGIN_BIT] && !st.beginReq &&
      st.state == ics_pkg::CH_IDLE && !busFree |=> !intN && !seqStart && (sdaFault || sclFault))
      else $error("busy bus begin not reported");

   single_pass_end_a : assert property (@(posedge sys_clk) disable iff (reset)
      engSeqEnd && st.state == ics_pkg::CH_ACTIVE && loopRepeatCount == ics_pkg::LOOP_ONE &&
      !(wrEdge && cmdHit) |=> !st.beginReq && st.state != ics_pkg::CH_ACTIVE)
      else $error("begin bit held after single pass");

endmodule : ics_channel_status

`default_nettype wire

// [hdl/ics_pkg.sv]
// Shared constants and types for the I2C channel result table and command logic
`default_nettype none

package ics_pkg;

   // Command register byte addresses, one per channel
   localparam logic [7:0] CMD_OFS_CH0      = 8'hC0;
   localparam logic [7:0] CMD_OFS_CH1      = 8'hD0;
   localparam logic [7:0] CMD_OFS_CH2      = 8'hE0;

   // Result table base addresses, 64 bytes per bank
   localparam logic [7:0] RESULT_OFS_A     = 8'h00;
   localparam logic [7:0] RESULT_OFS_B     = 8'h40;
   localparam logic [7:0] RESULT_OFS_C     = 8'h80;

   // Command register fields
   localparam int         CMD_HALT_SEQ_BIT  = 7;
   localparam int         CMD_BEGIN_BIT     = 6;
   localparam int         CMD_HALT_BYTE_BIT = 5;
   localparam logic [7:0] CMD_RESET         = 8'h00;
   localparam logic [4:0] CMD_LOW_MASK      = 5'h19;

   // Result byte fields
   localparam int         RES_RA_NACK      = 4;
   localparam int         RES_WA_NACK      = 3;
   localparam int         RES_DATA_NACK    = 2;
   localparam int         RES_ACTIVE       = 1;
   localparam int         RES_QUEUED       = 0;
   localparam int         RESULT_WIDTH     = 5;
   localparam logic [4:0] RESULT_RESET     = 5'h00;
   localparam logic [1:0] PHASE_ACTIVE     = 2'h2;
   localparam logic [1:0] PHASE_NONE       = 2'h0;
   localparam logic [2:0] RESULT_PAD       = 3'h0;
   localparam int         TABLE_DEPTH      = 64;

   // Loop repeat count values with meaning, and the byte read from an unmapped address
   localparam logic [7:0] LOOP_ONE         = 8'h01;
   localparam logic [7:0] LOOP_MAX         = 8'hFF;
   localparam logic [7:0] READ_NONE        = 8'h00;

   // Channel sequencing states
   typedef enum logic [1:0] {
      CH_IDLE,
      CH_ACTIVE,
      CH_STOPPING
   } ics_chan_t;

endpackage : ics_pkg

`default_nettype wire

// [hdl/ics_sync.sv]
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none

module ics_sync #(
   parameter int                WIDTH     = 1,
   parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset,
   // Levels
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stage1  <= RESET_VAL;
         syncOut <= RESET_VAL;
      end else begin
         stage1  <= pinIn;
         syncOut <= stage1;
      end
   end

endmodule : ics_sync

`default_nettype wire

// [testbench/ics_slave_model.sv]
// Far side of one channel: bus levels from the slaves plus the engine's transfer events
`timescale 1ns/10ps
`default_nettype none

module ics_slave_model (
   // Clock
   input  wire logic       sys_clk,
   // Bus levels, pulled up when released
   output logic            sclLine,
   output logic            sdaLine,
   // Engine events
   output logic            engXferBegin,
   output logic            engXferEnd,
   output logic            engSeqEnd,
   output logic [5:0]      engIndex,
   output logic [2:0]      engNack
);
   // Idle bus, no events
   initial begin
      {sclLine, sdaLine} = 2'h3;
      {engXferBegin, engXferEnd, engSeqEnd, engIndex, engNack} = '0;
   end

   // Pass k clock edges, then step just past the last one like the bench does
   task automatic waitC(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : waitC

   // Slaves stretching or stuck hold lines low: bit 1 clock, bit 0 data
   task automatic busLow(input logic [1:0] b);
      {sclLine, sdaLine} = ~b;
   endtask : busLow

   // START, two link clocks at 800 ns, then the running mark; clock parked low after
   task automatic beginX(input logic [5:0] idx);
      sdaLine = 1'b1;
      waitC(1);
      sclLine = 1'b1;
      waitC(4);
      sdaLine = 1'b0;
      waitC(4);
      sclLine = 1'b0;
      repeat (2) begin
         waitC(4);
         sclLine = 1'b1;
         waitC(4);
         sclLine = 1'b0;
      end
      waitC(1);
      engIndex = idx;
      engXferBegin = 1'b1;
      waitC(1);
      engXferBegin = 1'b0;
   endtask : beginX

   // End of one transfer; answer bits are read, write address, write data
   task automatic endX(input logic [5:0] idx, input logic [2:0] nk);
      @(posedge sys_clk) #1 engIndex = idx;
      engNack = nk;
      engXferEnd = 1'b1;
      @(posedge sys_clk) #1 engXferEnd = 1'b0;
      engNack = 3'h0;
   endtask : endX

   // One pass of the sequence is over
   task automatic seqEnd;
      @(posedge sys_clk) #1 engSeqEnd = 1'b1;
      @(posedge sys_clk) #1 engSeqEnd = 1'b0;
   endtask : seqEnd

   // STOP: both lines low first, so an idle bus still shows a real rise
   task automatic stopCond;
      sclLine = 1'b0;
      waitC(1);
      sdaLine = 1'b0;
      waitC(2);
      sclLine = 1'b1;
      waitC(4);
      sdaLine = 1'b1;
      waitC(1);
   endtask : stopCond
endmodule : ics_slave_model

`default_nettype wire

// [testbench/tb_i2c_channel_status_control.sv]
// Self-checking bench for one channel's result table and command logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(w, e, g) begin checksDone++; if ((g) !== (e)) begin numErrors++; $display("[ERR] %s exp %h got %h", w, e, g); end end

module tb_i2c_channel_status_control;
   logic       sys_clk, reset, hostCsN, hostRdN, hostWrN, sclIn, sdaIn;
   logic [7:0] hostAddr, hostDataIn, hostDataOut, loopRepeatCount;
   logic [6:0] loadedCount;
   logic       hostDataOeN, engXferBegin, engXferEnd, engSeqEnd;
   logic [5:0] engIndex;
   logic [2:0] engNack;
   logic       seqStart, haltAfterByte, haltAfterSequence, sdaFault, sclFault, intN;
   int         numErrors = 0, checksDone = 0, startCount = 0, n;

   ics_channel_status dut (.sys_clk(sys_clk), .reset(reset), .hostCsN(hostCsN), .hostRdN(hostRdN),
      .hostWrN(hostWrN), .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
      .hostDataOeN(hostDataOeN), .sclIn(sclIn), .sdaIn(sdaIn), .loopRepeatCount(loopRepeatCount),
      .loadedCount(loadedCount), .engXferBegin(engXferBegin), .engXferEnd(engXferEnd),
      .engSeqEnd(engSeqEnd), .engIndex(engIndex), .engReadAddrNack(engNack[2]),
      .engWriteAddrNack(engNack[1]), .engWriteByteNack(engNack[0]), .seqStart(seqStart),
      .haltAfterByte(haltAfterByte), .haltAfterSequence(haltAfterSequence), .sdaFault(sdaFault),
      .sclFault(sclFault), .intN(intN));
   ics_slave_model bus (.sys_clk(sys_clk), .sclLine(sclIn), .sdaLine(sdaIn), .engXferBegin(engXferBegin),
      .engXferEnd(engXferEnd), .engSeqEnd(engSeqEnd), .engIndex(engIndex), .engNack(engNack));

   // 100 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Start pulses are one cycle wide, so count them rather than poll
   always @(posedge sys_clk) if (seqStart === 1'b1) startCount <= startCount + 1;

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tick

   // Strobes stay low 4 cycles for writes, 5 for reads, and high 4, well past the synchroniser delay
   task automatic hostWr(input logic [7:0] a, input logic [7:0] d);
      hostAddr = a;
      hostDataIn = d;
      hostCsN = 1'b0;
      tick(3);
      hostWrN = 1'b0;
      tick(4);
      {hostWrN, hostCsN} = 2'h3;
      tick(4);
   endtask : hostWr

   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      hostAddr = a;
      hostCsN = 1'b0;
      tick(3);
      hostRdN = 1'b0;
      tick(5);
      `CHK("data drive", 1'b0, hostDataOeN)
      `CHK("read data", e, hostDataOut)
      {hostRdN, hostCsN} = 2'h3;
      tick(4);
   endtask : rdChk

   task automatic wrCmd(input logic [7:0] d);
      hostWr(ics_pkg::CMD_OFS_CH0, d);
   endtask : wrCmd

   task automatic tRegs;
      `CHK("int idle", 1'b1, intN)
      rdChk(8'h00, 8'h00);
      rdChk(8'h41, 8'h00);
      wrCmd(8'h1F);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h19);
      wrCmd(8'h00);
   endtask : tRegs

   // Begin marks entries, then each answer kind in turn
   task automatic tStart;
      loopRepeatCount = 8'h01;
      n = startCount;
      wrCmd(8'h40);
      `CHK("start pulses", n + 1, startCount)
      rdChk(8'h00, 8'h02);
      rdChk(8'h01, 8'h01);
      rdChk(8'h02, 8'h01);
      rdChk(8'h03, 8'h00);
      rdChk(8'h01, 8'h00);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h40);
      for (int k = 0; k < 3; k++) begin
         bus.beginX(6'(k));
         rdChk(8'(k), 8'h02);
         bus.endX(6'(k), 3'h4 >> k);
         tick(2);
         `CHK("int on answer", 1'b0, intN)
         rdChk(8'(k), 8'h10 >> k);
         `CHK("int after read", 1'b1, intN)
      end
      bus.seqEnd();
      tick(2);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h00);
      bus.stopCond();
   endtask : tStart

   // Auto-clear on every start for one pass, first start only for a loop
   task automatic tClear;
      wrCmd(8'h40);
      bus.beginX(6'h00);
      bus.endX(6'h00, 3'h4);
      bus.seqEnd();
      bus.stopCond();
      tick(2);
      `CHK("error left", 1'b0, intN)
      wrCmd(8'h40);
      rdChk(8'h00, 8'h02);
      `CHK("int cleared", 1'b1, intN)
      bus.seqEnd();
      bus.stopCond();
      loopRepeatCount = 8'h02;
      wrCmd(8'h40);
      bus.beginX(6'h00);
      bus.endX(6'h00, 3'h4);
      n = startCount;
      bus.seqEnd();
      tick(2);
      `CHK("next pass", n + 1, startCount)
      rdChk(8'h00, 8'h12);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h40);
      bus.seqEnd();
      tick(2);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h00);
      bus.stopCond();
   endtask : tClear

   // Endless loop halted at the end of the pass
   task automatic tHaltSeq;
      loopRepeatCount = 8'h00;
      wrCmd(8'h40);
      wrCmd(8'hC0);
      `CHK("halt seq", 1'b1, haltAfterSequence)
      bus.seqEnd();
      tick(2);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h80);
      n = startCount;
      bus.stopCond();
      tick(3);
      `CHK("halt seq cleared", 1'b0, haltAfterSequence)
      `CHK("no restart", n, startCount)
      rdChk(8'h01, 8'h00);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h00);
   endtask : tHaltSeq

   // Halt in mid-transfer; the begin bit in the same write is ignored
   task automatic tHaltByte;
      loopRepeatCount = 8'h01;
      wrCmd(8'h40);
      bus.beginX(6'h01);
      wrCmd(8'h60);
      `CHK("halt byte", 1'b1, haltAfterByte)
      bus.stopCond();
      tick(3);
      `CHK("halt byte cleared", 1'b0, haltAfterByte)
      rdChk(8'h01, 8'h00);
      rdChk(8'h02, 8'h00);
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h00);
   endtask : tHaltByte

   // Begin refused while a slave holds the data line, then the clock line
   task automatic tBusy;
      bus.busLow(2'h1);
      tick(4);
      n = startCount;
      wrCmd(8'h40);
      `CHK("data fault", 1'b1, sdaFault)
      `CHK("clock fault", 1'b0, sclFault)
      `CHK("int on fault", 1'b0, intN)
      `CHK("no start", n, startCount)
      rdChk(ics_pkg::CMD_OFS_CH0, 8'h00);
      bus.busLow(2'h2);
      tick(4);
      wrCmd(8'h40);
      `CHK("clock held", 1'b1, sclFault)
      `CHK("data free", 1'b0, sdaFault)
      `CHK("no start clock", n, startCount)
      bus.busLow(2'h0);
      tick(4);
      wrCmd(8'h40);
      `CHK("fault gone", 1'b0, sdaFault)
      `CHK("clock fault gone", 1'b0, sclFault)
      `CHK("start ok", n + 1, startCount)
      bus.seqEnd();
      bus.stopCond();
   endtask : tBusy

   task automatic print_verdict;
      $display("checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // Whole run is under a thousand cycles
   initial begin
      #3000000;
      numErrors++;
      print_verdict();
   end

   initial begin
      {reset, hostCsN, hostRdN, hostWrN} = 4'hF;
      {hostAddr, hostDataIn, loopRepeatCount} = '0;
      loadedCount = 7'h03;
      tick(8);
      reset = 1'b0;
      tick(3);
      tRegs();
      tStart();
      tClear();
      tHaltSeq();
      tHaltByte();
      tBusy();
      print_verdict();
   end
endmodule : tb_i2c_channel_status_control

`default_nettype wire
